// ==== rtl/lvd_map.svh ====
// register map, field positions, reset values and timing constants
`ifndef LVD_MAP_SVH
`define LVD_MAP_SVH

// ---------------------------------------------------------------
// register indices (byte address is four times the index)
// ---------------------------------------------------------------
`define LVD_IDX_PORT12_DIR 16'hff2c
`define LVD_IDX_CONTROL    16'hffbe
`define LVD_IDX_LEVEL_SEL  16'hffbf
`define LVD_IDX_IRQ        16'hffc0
`define LVD_IDX_CAUSE      16'hffc1

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define LVD_CTL_ENABLE 7
`define LVD_CTL_SOURCE 2
`define LVD_CTL_MODE   1
`define LVD_CTL_FLAG   0
`define LVD_IRQ_REQ    0
`define LVD_IRQ_MASK   1
`define LVD_CAUSE_BIT  0
`define LVD_CODE_MSB   3

// ---------------------------------------------------------------
// reset values and fixed bits
// ---------------------------------------------------------------
`define LVD_PORT12_RST   8'hff
`define LVD_PORT12_FIXED 8'he0
`define LVD_LEVEL_RST    4'h0
`define LVD_ZERO_BYTE    8'h00

// ---------------------------------------------------------------
// timing, in nanoseconds
// ---------------------------------------------------------------
`define LVD_CLK_NS     25
`define LVD_SETTLE_NS  10000
`define LVD_PERSIST_NS 200000

// ---------------------------------------------------------------
// bus answers
// ---------------------------------------------------------------
`define LVD_RESP_OKAY   2'b00
`define LVD_RESP_SLVERR 2'b10

`endif

// ==== rtl/lvd_pkg.sv ====
// types shared by the low-voltage detect control logic
package lvd_pkg;

   // ------------------------------------------------------------
   // register contents
   // ------------------------------------------------------------
   typedef struct packed {
      logic enable;
      logic source;
      logic mode;
   } ctrl_t;

   typedef struct packed {
      logic mask;
      logic req;
   } irq_t;

   // comparator steering driven to the analog side
   typedef struct packed {
      logic       enable;
      logic       source;
      logic [3:0] level;
   } comp_ctl_t;

   // ------------------------------------------------------------
   // bus decode and channel states
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      SEL_NONE  = 3'b000,
      SEL_PORT  = 3'b001,
      SEL_CTRL  = 3'b010,
      SEL_LEVEL = 3'b011,
      SEL_IRQ   = 3'b100,
      SEL_CAUSE = 3'b101
   } reg_sel_t;

   typedef enum logic [0:0] {
      WR_COLLECT = 1'b0,
      WR_RESP    = 1'b1
   } wr_state_t;

   typedef enum logic [0:0] {
      RD_IDLE = 1'b0,
      RD_DATA = 1'b1
   } rd_state_t;

endpackage : lvd_pkg

// ==== rtl/lvd_sync.sv ====
// two-flop synchroniser for the comparator output
module lvd_sync (
   input  wire logic ref_clk,
   input  wire logic reset,
   input  wire logic async_in,
   output logic      sync_out
);

   logic meta;

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         meta     <= 1'b0;
         sync_out <= 1'b0;
      end else begin
         meta     <= async_in;
         sync_out <= meta;
      end
   end

endmodule : lvd_sync

// ==== rtl/lvd_persist.sv ====
// below-level flag that needs a persistent condition before it sets
module lvd_persist #(
   parameter int unsigned PERSIST_CYC = 8000
) (
   input  wire logic ref_clk,
   input  wire logic reset,
   input  wire logic run,
   input  wire logic below,
   output logic      below_level_flag
);

   localparam int unsigned CNT_W = $clog2(PERSIST_CYC + 1);
   localparam logic [CNT_W-1:0] CNT_END = CNT_W'(PERSIST_CYC - 1);
   localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

   logic [CNT_W-1:0] cnt;
   logic [CNT_W-1:0] next_cnt;
   logic             next_flag;

   always_comb begin
      next_cnt  = cnt;
      next_flag = below_level_flag;
      if (!run || !below) begin
         next_cnt  = '0;
         next_flag = 1'b0;
      end else if (!below_level_flag) begin
         if (cnt == CNT_END) begin
            next_flag = 1'b1;
         end else begin
            next_cnt = cnt + CNT_ONE;
         end
      end
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         cnt              <= '0;
         below_level_flag <= 1'b0;
      end else begin
         cnt              <= next_cnt;
         below_level_flag <= next_flag;
      end
   end

endmodule : lvd_persist

// ==== rtl/low_voltage_detect_control.sv ====
// low-voltage detect control: register bank, filter, reset and events
//
// Summary of operation
// - enable bit starts comparator, gates all but the fall event on disable
// - control bit 2 picks supply or pin
// - reset mode: hold reset while below
// - interrupt mode: event on both crossings
// - bit 0 reads live below flag
// - outside resets clear enable, source, mode
// - outside resets clear level select
// - flag sets after 200 us below
// - disable while below raises interrupt in interrupt mode
// - four-bit level code, upper bits zero
// - pin source ignores level code
// - entering reset mode above gives no pulse
// - any reset sets interrupt mask
// - port direction resets to all ones
// - detector reset records its cause
`include "lvd_map.svh"

module low_voltage_detect_control #(
   parameter int unsigned PERSIST_CYC =
      (`LVD_PERSIST_NS + `LVD_CLK_NS - 1) / `LVD_CLK_NS
) (
   input  wire logic             ref_clk,
   input  wire logic             reset,
   input  wire logic [17:0]      awaddr,
   input  wire logic             awvalid,
   output logic                  awready,
   input  wire logic [31:0]      wdata,
   input  wire logic [3:0]       wstrb,
   input  wire logic             wvalid,
   output logic                  wready,
   output logic [1:0]            bresp,
   output logic                  bvalid,
   input  wire logic             bready,
   input  wire logic [17:0]      araddr,
   input  wire logic             arvalid,
   output logic                  arready,
   output logic [31:0]           rdata,
   output logic [1:0]            rresp,
   output logic                  rvalid,
   input  wire logic             rready,
   input  wire logic             comp_below,
   output lvd_pkg::comp_ctl_t    comp_ctl,
   output logic [7:0]            port12_direction,
   output logic                  lvd_reset,
   output logic                  undervolt_irq,
   output logic                  undervolt_irq_request,
   output logic                  irq_pending
);

   localparam int unsigned SETTLE_CYC =
      (`LVD_SETTLE_NS + `LVD_CLK_NS - 1) / `LVD_CLK_NS;
   localparam int unsigned SETTLE_W = $clog2(SETTLE_CYC + 1);
   localparam logic [SETTLE_W-1:0] SETTLE_END = SETTLE_W'(SETTLE_CYC);
   localparam logic [SETTLE_W-1:0] SETTLE_ONE = SETTLE_W'(1);

   // ---------------------------------------------------------------
   // address decode
   // ---------------------------------------------------------------
   function automatic lvd_pkg::reg_sel_t reg_sel(input logic [17:0] a);
      reg_sel = lvd_pkg::SEL_NONE;
      if (a[1:0] == 2'h0) begin
         case (a[17:2])
            `LVD_IDX_PORT12_DIR: reg_sel = lvd_pkg::SEL_PORT;
            `LVD_IDX_CONTROL:    reg_sel = lvd_pkg::SEL_CTRL;
            `LVD_IDX_LEVEL_SEL:  reg_sel = lvd_pkg::SEL_LEVEL;
            `LVD_IDX_IRQ:        reg_sel = lvd_pkg::SEL_IRQ;
            `LVD_IDX_CAUSE:      reg_sel = lvd_pkg::SEL_CAUSE;
            default:             reg_sel = lvd_pkg::SEL_NONE;
         endcase
      end
   endfunction : reg_sel

   lvd_pkg::ctrl_t    ctrl;
   lvd_pkg::ctrl_t    next_ctrl;
   lvd_pkg::irq_t     irq;
   lvd_pkg::irq_t     next_irq;
   logic [3:0]        level;
   logic [3:0]        next_level;
   logic [7:0]        next_port12;
   logic              cause;
   logic              next_cause;
   logic              below_sync;
   logic              below_level_flag;
   logic              irq_event;

   // ---------------------------------------------------------------
   // write channel
   // ---------------------------------------------------------------
   lvd_pkg::wr_state_t wr_state;
   lvd_pkg::wr_state_t next_wr_state;
   logic              aw_held;
   logic              next_aw_held;
   logic              w_held;
   logic              next_w_held;
   logic [17:0]       waddr_q;
   logic [17:0]       next_waddr_q;
   logic [7:0]        wbyte_q;
   logic [7:0]        next_wbyte_q;
   logic              wlane_q;
   logic              next_wlane_q;
   logic [1:0]        next_bresp;
   logic              do_write;
   lvd_pkg::reg_sel_t wsel;

   assign awready  = (wr_state == lvd_pkg::WR_COLLECT) && !aw_held;
   assign wready   = (wr_state == lvd_pkg::WR_COLLECT) && !w_held;
   assign bvalid   = (wr_state == lvd_pkg::WR_RESP);
   assign do_write = (wr_state == lvd_pkg::WR_COLLECT) && aw_held && w_held;
   assign wsel     = reg_sel(waddr_q);

   always_comb begin
      next_wr_state = wr_state;
      next_aw_held  = aw_held;
      next_w_held   = w_held;
      next_waddr_q  = waddr_q;
      next_wbyte_q  = wbyte_q;
      next_wlane_q  = wlane_q;
      next_bresp    = bresp;
      if (awvalid && awready) begin
         next_aw_held = 1'b1;
         next_waddr_q = awaddr;
      end
      if (wvalid && wready) begin
         next_w_held  = 1'b1;
         next_wbyte_q = wdata[7:0];
         next_wlane_q = wstrb[0];
      end
      case (wr_state)
         lvd_pkg::WR_COLLECT: begin
            if (do_write) begin
               next_wr_state = lvd_pkg::WR_RESP;
               next_bresp    = (wsel == lvd_pkg::SEL_NONE) ?
                               `LVD_RESP_SLVERR : `LVD_RESP_OKAY;
            end
         end
         lvd_pkg::WR_RESP: begin
            if (bready) begin
               next_wr_state = lvd_pkg::WR_COLLECT;
               next_aw_held  = 1'b0;
               next_w_held   = 1'b0;
            end
         end
         default: next_wr_state = lvd_pkg::WR_COLLECT;
      endcase
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         wr_state <= lvd_pkg::WR_COLLECT;
         aw_held  <= 1'b0;
         w_held   <= 1'b0;
         waddr_q  <= '0;
         wbyte_q  <= '0;
         wlane_q  <= 1'b0;
         bresp    <= `LVD_RESP_OKAY;
      end else begin
         wr_state <= next_wr_state;
         aw_held  <= next_aw_held;
         w_held   <= next_w_held;
         waddr_q  <= next_waddr_q;
         wbyte_q  <= next_wbyte_q;
         wlane_q  <= next_wlane_q;
         bresp    <= next_bresp;
      end
   end

   // ---------------------------------------------------------------
   // read channel
   // ---------------------------------------------------------------
   lvd_pkg::rd_state_t rd_state;
   lvd_pkg::rd_state_t next_rd_state;
   logic [7:0]        rbyte;
   logic [31:0]       next_rdata;
   logic [1:0]        next_rresp;

   assign arready = (rd_state == lvd_pkg::RD_IDLE);
   assign rvalid  = (rd_state == lvd_pkg::RD_DATA);

   always_comb begin
      rbyte = `LVD_ZERO_BYTE;
      case (reg_sel(araddr))
         lvd_pkg::SEL_PORT: rbyte = port12_direction;
         lvd_pkg::SEL_CTRL: begin
            rbyte[`LVD_CTL_ENABLE] = ctrl.enable;
            rbyte[`LVD_CTL_SOURCE] = ctrl.source;
            rbyte[`LVD_CTL_MODE]   = ctrl.mode;
            rbyte[`LVD_CTL_FLAG]   = below_level_flag;
         end
         lvd_pkg::SEL_LEVEL: rbyte[`LVD_CODE_MSB:0] = level;
         lvd_pkg::SEL_IRQ: begin
            rbyte[`LVD_IRQ_REQ]  = irq.req;
            rbyte[`LVD_IRQ_MASK] = irq.mask;
         end
         lvd_pkg::SEL_CAUSE: rbyte[`LVD_CAUSE_BIT] = cause;
         default: rbyte = `LVD_ZERO_BYTE;
      endcase
   end

   always_comb begin
      next_rd_state = rd_state;
      next_rdata    = rdata;
      next_rresp    = rresp;
      case (rd_state)
         lvd_pkg::RD_IDLE: begin
            if (arvalid) begin
               next_rd_state = lvd_pkg::RD_DATA;
               next_rdata    = {24'h000000, rbyte};
               next_rresp    = (reg_sel(araddr) == lvd_pkg::SEL_NONE) ?
                               `LVD_RESP_SLVERR : `LVD_RESP_OKAY;
            end
         end
         lvd_pkg::RD_DATA: begin
            if (rready) begin
               next_rd_state = lvd_pkg::RD_IDLE;
            end
         end
         default: next_rd_state = lvd_pkg::RD_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         rd_state <= lvd_pkg::RD_IDLE;
         rdata    <= '0;
         rresp    <= `LVD_RESP_OKAY;
      end else begin
         rd_state <= next_rd_state;
         rdata    <= next_rdata;
         rresp    <= next_rresp;
      end
   end

   // ---------------------------------------------------------------
   // register bank
   // ---------------------------------------------------------------
   // the outside reset clears these but sets irq mask and port direction to all ones; lvd_reset only sets irq mask and cause and forces port direction to all ones
   always_comb begin
      next_ctrl   = ctrl;
      next_level  = level;
      next_port12 = port12_direction;
      next_irq    = irq;
      next_cause  = cause;
      if (do_write && wlane_q) begin
         case (wsel)
            lvd_pkg::SEL_PORT: begin
               next_port12 = wbyte_q | `LVD_PORT12_FIXED;
            end
            lvd_pkg::SEL_CTRL: begin
               next_ctrl.enable = wbyte_q[`LVD_CTL_ENABLE];
               next_ctrl.source = wbyte_q[`LVD_CTL_SOURCE];
               next_ctrl.mode   = wbyte_q[`LVD_CTL_MODE];
            end
            lvd_pkg::SEL_LEVEL: begin
               next_level = wbyte_q[`LVD_CODE_MSB:0];
            end
            lvd_pkg::SEL_IRQ: begin
               next_irq.req  = wbyte_q[`LVD_IRQ_REQ];
               next_irq.mask = wbyte_q[`LVD_IRQ_MASK];
            end
            lvd_pkg::SEL_CAUSE: begin
               if (wbyte_q[`LVD_CAUSE_BIT]) begin
                  next_cause = 1'b0;
               end
            end
            default: next_cause = cause;
         endcase
      end
      // hardware sets win over software clears
      if (irq_event) begin
         next_irq.req = 1'b1;
      end
      if (lvd_reset) begin
         next_irq.mask = 1'b1;
         next_port12   = `LVD_PORT12_RST;
         next_cause    = 1'b1;
      end
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         ctrl             <= '0;
         level            <= `LVD_LEVEL_RST;
         port12_direction <= `LVD_PORT12_RST;
         irq.req          <= 1'b0;
         irq.mask         <= 1'b1;
         cause            <= 1'b0;
      end else begin
         ctrl             <= next_ctrl;
         level            <= next_level;
         port12_direction <= next_port12;
         irq              <= next_irq;
         cause            <= next_cause;
      end
   end

   assign undervolt_irq_request = irq.req;
   assign irq_pending           = irq.req && !irq.mask;

   // ---------------------------------------------------------------
   // comparator steering and detection
   // ---------------------------------------------------------------
   assign comp_ctl = {ctrl.enable,
                      ctrl.source,
                      ctrl.source ? `LVD_LEVEL_RST : level};

   lvd_sync u_sync (
      .ref_clk  (ref_clk),
      .reset    (reset),
      .async_in (comp_below),
      .sync_out (below_sync)
   );

   logic [SETTLE_W-1:0] settle_cnt;
   logic [SETTLE_W-1:0] next_settle_cnt;
   logic                settled;
   logic                flag_prev;
   logic                mode_prev;
   logic                next_lvd_reset;
   logic                next_irq_pulse;

   assign settled = (settle_cnt == SETTLE_END);

   lvd_persist #(
      .PERSIST_CYC (PERSIST_CYC)
   ) u_persist (
      .ref_clk          (ref_clk),
      .reset            (reset),
      .run              (ctrl.enable && settled),
      .below            (below_sync),
      .below_level_flag (below_level_flag)
   );

   // crossing events in interrupt mode, including the fall on disable
   assign irq_event = (below_level_flag ^ flag_prev) && !mode_prev;

   always_comb begin
      next_settle_cnt = settle_cnt;
      if (!ctrl.enable) begin
         next_settle_cnt = '0;
      end else if (!settled) begin
         next_settle_cnt = settle_cnt + SETTLE_ONE;
      end
      // flag is low when above, so mode set above gives no pulse
      next_lvd_reset = ctrl.enable && ctrl.mode && below_level_flag;
      next_irq_pulse = irq_event;
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         settle_cnt    <= '0;
         flag_prev     <= 1'b0;
         mode_prev     <= 1'b0;
         lvd_reset     <= 1'b0;
         undervolt_irq <= 1'b0;
      end else begin
         settle_cnt    <= next_settle_cnt;
         flag_prev     <= below_level_flag;
         mode_prev     <= ctrl.mode;
         lvd_reset     <= next_lvd_reset;
         undervolt_irq <= next_irq_pulse;
      end
   end

endmodule : low_voltage_detect_control

// ==== dv/lvd_comp_model.sv ====
// behavioural comparator and reference ladder on the analog side
module lvd_comp_model #(
   parameter int EXT_REF_MV = 1210,
   parameter int TOP_MV     = 4240,
   parameter int STEP_MV    = 155
) (
   input  wire logic               ref_clk,
   input  wire lvd_pkg::comp_ctl_t comp_ctl,
   input  wire logic signed [31:0] vdd_mv,
   input  wire logic signed [31:0] pin_mv,
   output logic                    comp_below
);
   // output wanders while the comparator is off
   logic idle_pat = 1'b0;
   always @(posedge ref_clk) idle_pat <= ~idle_pat;
   always_comb begin
      if (!comp_ctl.enable)
         comp_below = idle_pat;
      else if (comp_ctl.source)
         comp_below = pin_mv < EXT_REF_MV;
      else
         comp_below = vdd_mv < TOP_MV - STEP_MV * int'(comp_ctl.level);
   end
endmodule : lvd_comp_model

// ==== dv/lvd_chk.sv ====
// concurrent checks on the detect control block ports
module lvd_chk #(
   parameter int unsigned PERSIST_CYC = 8000
) (
   input wire logic               ref_clk,
   input wire logic               reset,
   input wire logic               comp_below,
   input wire lvd_pkg::comp_ctl_t comp_ctl,
   input wire logic [7:0]         port12_direction,
   input wire logic               lvd_reset,
   input wire logic               undervolt_irq,
   input wire logic               undervolt_irq_request,
   input wire logic               irq_pending,
   input wire logic               bvalid,
   input wire logic [1:0]         bresp
);
   // ---------------------------------------------------------------
   // run length of the raw comparator output
   // ---------------------------------------------------------------
   logic [15:0] below_run;
   logic [15:0] next_below_run;
   always_comb begin
      next_below_run = below_run;
      if (!comp_below)
         next_below_run = '0;
      else if (below_run != 16'hffff)
         next_below_run = below_run + 16'h0001;
   end
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset)
         below_run <= '0;
      else
         below_run <= next_below_run;
   end
   // ---------------------------------------------------------------
   // properties
   // ---------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);
   rst_needs_en_a: assert property ($rose(lvd_reset) |-> $past(comp_ctl.enable))
      else $error("detector reset without enable");
   irq_needs_en_a: assert property (undervolt_irq |-> $past(comp_ctl.enable, 3))
      else $error("event pulse with detection off");
   irq_sets_req_a: assert property (undervolt_irq |-> undervolt_irq_request)
      else $error("event pulse without request flag");
   pend_masked_a: assert property ($past(lvd_reset) |-> !irq_pending)
      else $error("pending not masked after detector reset");
   no_irq_rst_a: assert property (lvd_reset |-> !undervolt_irq)
      else $error("event pulse in reset mode");
   port_forced_a: assert property ($past(lvd_reset) |-> port12_direction == 8'hff)
      else $error("direction not all inputs after detector reset");
   port_fixed_a: assert property (port12_direction[7:5] == 3'b111)
      else $error("fixed direction bits not one");
   pin_level_a: assert property (comp_ctl.source |-> comp_ctl.level == 4'h0)
      else $error("level code driven with pin source");
   rst_persist_a: assert property ($rose(lvd_reset) |-> below_run >= PERSIST_CYC)
      else $error("detector reset before persistence time");
   rst_release_a: assert property (!comp_below [*5] |-> !lvd_reset)
      else $error("detector reset held while above");
   cover property (undervolt_irq);
   cover property ($rose(lvd_reset));
   cover property ($fell(lvd_reset));
   cover property (bvalid && bresp == 2'b10);
endmodule : lvd_chk

bind low_voltage_detect_control lvd_chk #(.PERSIST_CYC(PERSIST_CYC)) i_lvd_chk (
   .ref_clk, .reset, .comp_below, .comp_ctl, .port12_direction, .lvd_reset,
   .undervolt_irq, .undervolt_irq_request, .irq_pending, .bvalid, .bresp);

// ==== dv/tb.sv ====
// self-checking bench for the low-voltage detect control block
`include "lvd_map.svh"
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int          PC    = 8;
   localparam int          WT    = PC + 8;
   localparam logic [17:0] A_PRT = {`LVD_IDX_PORT12_DIR, 2'b00};
   localparam logic [17:0] A_CTL = {`LVD_IDX_CONTROL, 2'b00};
   localparam logic [17:0] A_LVL = {`LVD_IDX_LEVEL_SEL, 2'b00};
   localparam logic [17:0] A_IRQ = {`LVD_IDX_IRQ, 2'b00};
   localparam logic [17:0] A_CAU = {`LVD_IDX_CAUSE, 2'b00};
   localparam logic [17:0] A_BAD = 18'h3fff0;
   logic               ref_clk = 1'b0;
   logic               reset   = 1'b1;
   logic [17:0]        awaddr  = '0;
   logic [17:0]        araddr  = '0;
   logic [31:0]        wdata   = '0;
   logic [3:0]         wstrb   = 4'hf;
   logic               awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic               arvalid = 1'b0, rready = 1'b0;
   logic               awready, wready, bvalid, arready, rvalid, comp_below;
   logic               lvd_reset, undervolt_irq, undervolt_irq_request;
   logic               irq_pending;
   logic [1:0]         bresp, rresp;
   logic [31:0]        rdata, x;
   logic [7:0]         port12_direction;
   lvd_pkg::comp_ctl_t comp_ctl;
   logic [31:0]        rs = 32'h036c;
   int                 vdd_mv = 5000, pin_mv = 2000;
   int                 err_total = 0, checks_done = 0, irq_cnt = 0;
   int                 m_prt, m_ctl, m_lvl, m_irq, m_cau;

   always #12.5 ref_clk = ~ref_clk;
   always @(posedge ref_clk) if (undervolt_irq === 1'b1) irq_cnt <= irq_cnt + 1;

   low_voltage_detect_control #(.PERSIST_CYC(PC)) i_low_voltage_detect_control (
      .ref_clk, .reset, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
      .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
      .rresp, .rvalid, .rready, .comp_below, .comp_ctl, .port12_direction,
      .lvd_reset, .undervolt_irq, .undervolt_irq_request, .irq_pending);
   lvd_comp_model i_lvd_comp_model (
      .ref_clk, .comp_ctl, .vdd_mv, .pin_mv, .comp_below);

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function automatic logic [31:0] xs();
      rs ^= rs << 13;
      rs ^= rs >> 17;
      rs ^= rs << 5;
      return rs;
   endfunction : xs

   function automatic logic [1:0] resp_of(input logic [17:0] a);
      return (a inside {A_PRT, A_CTL, A_LVL, A_IRQ, A_CAU}) ? 2'b00 : 2'b10;
   endfunction : resp_of

   function automatic int mdl(input logic [17:0] a);
      case (a)
         A_PRT: return m_prt;
         A_CTL: return m_ctl;
         A_LVL: return m_lvl;
         A_IRQ: return m_irq;
         A_CAU: return m_cau;
         default: return 0;
      endcase
   endfunction : mdl

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks_done++;
      if (g !== e) begin
         $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
         err_total++;
      end
   endtask : chk

   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
   endtask : cyc

   task automatic wr(input logic [17:0] a, input logic [7:0] d);
      bit ad, dd;
      ad = 0;
      dd = 0;
      awaddr <= a;
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      while (!(ad && dd)) begin
         @(posedge ref_clk);
         if (!ad && awready === 1'b1) begin
            ad = 1;
            awvalid <= 1'b0;
         end
         if (!dd && wready === 1'b1) begin
            dd = 1;
            wvalid <= 1'b0;
         end
      end
      bready <= 1'b1;
      do @(posedge ref_clk); while (bvalid !== 1'b1);
      bready <= 1'b0;
      chk(bresp, resp_of(a));
      case (a)
         A_PRT: m_prt = d | 8'he0;
         A_CTL: m_ctl = d & 8'h86;
         A_LVL: m_lvl = d & 8'h0f;
         A_IRQ: m_irq = d & 8'h03;
         A_CAU: m_cau = d[0] ? 0 : m_cau;
         default: ;
      endcase
   endtask : wr

   task automatic rd(input logic [17:0] a, input logic [31:0] flag);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge ref_clk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge ref_clk); while (rvalid !== 1'b1);
      rready <= 1'b0;
      chk(rdata, mdl(a) | flag);
      chk(rresp, resp_of(a));
   endtask : rd

   task automatic give_verdict();
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : give_verdict

   initial begin
      cyc(20000);
      err_total++;
      give_verdict();
   end

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      m_prt = 8'hff; m_ctl = 0; m_lvl = 0; m_irq = 2; m_cau = 0;
      cyc(2);
      reset <= 1'b0;
      cyc(1);
      rd(A_PRT, 0);
      rd(A_CTL, 0);
      rd(A_LVL, 0);
      rd(A_IRQ, 0);
      rd(A_CAU, 0);
      rd(A_BAD, 0);
      wr(A_BAD, 8'hff);
      x = xs();
      wr(A_PRT, x[7:0]);
      rd(A_PRT, 0);
      x = xs();
      for (int i = 0; i < 16; i++) begin
         wr(A_LVL, {4'h0, x[3:0] ^ i[3:0]});
         chk(comp_ctl.level, x[3:0] ^ i[3:0]);
         rd(A_LVL, 0);
      end
      wr(A_LVL, 8'h05);
      wr(A_CTL, 8'h84);
      chk(comp_ctl, 6'h30);
      wr(A_CTL, 8'h00);
      chk(comp_ctl, 6'h05);
      // interrupt mode on the supply rail
      wr(A_CTL, 8'h80);
      cyc(450);
      rd(A_CTL, 0);
      wr(A_IRQ, 8'h00);
      vdd_mv <= 3000;
      cyc(WT);
      rd(A_CTL, 1);
      chk(irq_cnt, 1);
      chk(irq_pending, 1'b1);
      wr(A_IRQ, 8'h00);
      vdd_mv <= 5000;
      cyc(WT);
      rd(A_CTL, 0);
      chk(irq_cnt, 2);
      vdd_mv <= 3000;
      cyc(PC / 2);
      vdd_mv <= 5000;
      cyc(WT);
      rd(A_CTL, 0);
      chk(irq_cnt, 2);
      vdd_mv <= 3000;
      cyc(WT);
      chk(irq_cnt, 3);
      wr(A_IRQ, 8'h02);
      wr(A_CTL, 8'h00);
      cyc(10);
      chk(irq_cnt, 4);
      chk(undervolt_irq_request, 1'b1);
      m_irq = 3;
      rd(A_IRQ, 0);
      rd(A_CTL, 0);
      chk(irq_pending, 1'b0);
      // reset mode on the supply rail
      vdd_mv <= 5000;
      wr(A_CTL, 8'h80);
      cyc(450);
      wr(A_CTL, 8'h82);
      cyc(WT);
      chk(lvd_reset, 1'b0);
      vdd_mv <= 3000;
      cyc(WT);
      chk(lvd_reset, 1'b1);
      chk(port12_direction, 8'hff);
      m_prt = 8'hff; m_cau = 1;
      rd(A_CTL, 1);
      rd(A_LVL, 0);
      rd(A_IRQ, 0);
      rd(A_CAU, 0);
      rd(A_PRT, 0);
      vdd_mv <= 5000;
      cyc(WT);
      chk(lvd_reset, 1'b0);
      wr(A_CTL, 8'h80);
      wr(A_CTL, 8'h00);
      wr(A_CAU, 8'h01);
      rd(A_CAU, 0);
      reset <= 1'b1;
      cyc(2);
      reset <= 1'b0;
      cyc(1);
      m_prt = 8'hff; m_ctl = 0; m_lvl = 0; m_irq = 2; m_cau = 0;
      rd(A_CTL, 0);
      rd(A_LVL, 0);
      rd(A_IRQ, 0);
      give_verdict();
   end
endmodule : tb
